// ---- hw/hcm_bus_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************
// Byte-wide micro bus between the host and the device
// ****************************************************
interface hcm_bus_if;
  hcm_pkg::hcm_addr_t addr; // Register address
  hcm_pkg::hcm_byte_t wdata; // Write data
  logic wr; // Write strobe, one cycle
  logic rd; // Read strobe, one cycle
  hcm_pkg::hcm_byte_t rdata; // Read data, cycle after rd
  logic irq; // Interrupt line, active high

  modport dev (input addr, input wdata, input wr, input rd, output rdata, output irq);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface : hcm_bus_if

`default_nettype wire

// ---- hw/hcm_defs.svh ----
`ifndef HCM_DEFS_SVH
`define HCM_DEFS_SVH

// ****************************************************
// Register offsets in the 4-bit address space of the byte-wide micro bus
// ****************************************************
`define HCM_OFS_MASK 4'h1
`define HCM_OFS_CAUSE 4'h2
`define HCM_OFS_HOST_CMD 4'h3
`define HCM_OFS_DEV_CMD 4'h4
`define HCM_OFS_INIT 4'h5
`define HCM_OFS_FORCE 4'h6
`define HCM_OFS_PTR_HI 4'hC
`define HCM_OFS_PTR_LO 4'hD
`define HCM_OFS_RAM_NEXT 4'hE
`define HCM_OFS_RAM_CUR 4'hF

// ****************************************************
// Flag positions, masks and reset values
// ****************************************************
`define HCM_BIT_HOST_TAKEN 0
`define HCM_BIT_BUS_RESET 1
`define HCM_BIT_DEV_POSTED 2
`define HCM_FLAG_MASK 8'h07
`define HCM_FORCE_MASK 8'h05
`define HCM_RST_BYTE 8'h00

// ****************************************************
// Shared RAM size (16 kbyte, byte addressed)
// ****************************************************
`define HCM_RAM_AW 14
`define HCM_SYNC_RST 2'h0

`endif

// ---- hw/hcm_dev_end.sv ----
// Operation
// - Host loads image through RAM data port
// - Any init write starts the engine
// - Engine consuming host command sets bit 0
// - Consumed host command byte stays readable
// - Write one clears host-taken, zero ignored
// - New host command clears host-taken flag
// - Init value meaningless, reads zero
// - Engine command post sets bit 2
// - Engine parameters reach RAM before command
// - Write one acks device command, drops irq
// - Ack keeps byte; engine waits for ack
// - Interrupt is OR of flag AND mask
// - Cause reads return unmasked flags
// - Force write one sets flag, zero ignored
// - Force write-only, bits 0 and 2 only
// - Host should force only host-taken
// - Mask and cause share one bit layout
// - Parameterless command needs only command byte
// - Host-taken sets even when masked
// - Serial bus reset sets bit 1
// - Next port uses pointer then increments
`timescale 1ns/1ps
`default_nettype none
`include "hcm_defs.svh"

module hcm_dev_end #(
  parameter int RAM_AW = `HCM_RAM_AW
) (
  input wire logic core_clk_i, // System clock, 40 MHz
  input wire logic rstn_i, // Async reset, active low
  hcm_bus_if.dev bus, // Micro bus toward the host end
  input wire logic eng_take_i, // Engine consumed host command
  output logic [7:0] host_cmd_o, // Last host command byte
  output logic host_cmd_new_o, // Host command not yet consumed
  input wire logic eng_post_i, // Engine posts a command byte
  input wire logic [7:0] eng_post_byte_i, // Byte being posted
  output logic eng_post_ready_o, // Post accepted (no ack pending)
  input wire logic eng_ram_we_i, // Engine RAM write strobe
  input wire logic [RAM_AW-1:0] eng_ram_addr_i, // Engine RAM address
  input wire logic [7:0] eng_ram_wdata_i, // Engine RAM write data
  output logic [7:0] eng_ram_rdata_o, // Engine RAM read data, next cycle
  input wire logic serial_bus_reset_i, // Serial bus reset level, async
  output logic engine_run_o // Power-on sequence done
);

  // ****************************************************
  // State
  // ****************************************************
  logic [7:0] ram [0:(1 << RAM_AW)-1];
  hcm_pkg::hcm_byte_t flags, next_flags;
  hcm_pkg::hcm_byte_t mask, next_mask;
  hcm_pkg::hcm_byte_t host_cmd, next_host_cmd;
  hcm_pkg::hcm_byte_t dev_cmd, next_dev_cmd;
  hcm_pkg::hcm_byte_t rdata, next_rdata;
  logic [RAM_AW-1:0] ptr, next_ptr;
  logic host_new, next_host_new;
  logic run, next_run;
  logic post_ready, next_post_ready;
  logic irq, next_irq;
  logic sbr_s1, sbr_s2, sbr_d;
  logic sbr_event;
  logic host_ram_we;
  hcm_pkg::hcm_byte_t set_bits, clr_bits;

  // ****************************************************
  // Serial bus reset synchroniser and edge detect
  // ****************************************************
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sbr_s1 <= 1'b0;
      sbr_s2 <= 1'b0;
      sbr_d <= 1'b0;
    end
    else
    begin
      sbr_s1 <= serial_bus_reset_i;
      sbr_s2 <= sbr_s1;
      sbr_d <= sbr_s2;
    end
  end

  // Rising edge of the synchronised level
  assign sbr_event = sbr_s2 & ~sbr_d;

  // ****************************************************
  // Flag set and clear terms
  // ****************************************************
  always_comb
  begin
    set_bits = 8'h00;
    clr_bits = 8'h00;
    // Engine consumption sets host-taken regardless of mask
    if (eng_take_i)
      set_bits[`HCM_BIT_HOST_TAKEN] = 1'b1;
    if (sbr_event)
      set_bits[`HCM_BIT_BUS_RESET] = 1'b1;
    // A post is taken only while no earlier post awaits ack
    if (eng_post_i && post_ready)
      set_bits[`HCM_BIT_DEV_POSTED] = 1'b1;
    if (bus.wr && bus.addr == `HCM_OFS_FORCE)
      set_bits = set_bits | (bus.wdata & `HCM_FORCE_MASK);
    if (bus.wr && bus.addr == `HCM_OFS_CAUSE)
      clr_bits = bus.wdata & `HCM_FLAG_MASK;
    if (bus.wr && bus.addr == `HCM_OFS_HOST_CMD)
      clr_bits[`HCM_BIT_HOST_TAKEN] = 1'b1;
  end

  // ****************************************************
  // Register file next values and read mux
  // ****************************************************
  always_comb
  begin
    // A set in the same cycle as a clear wins
    next_flags = ((flags & ~clr_bits) | set_bits) & `HCM_FLAG_MASK;
    next_mask = mask;
    next_host_cmd = host_cmd;
    next_host_new = host_new;
    next_dev_cmd = dev_cmd;
    next_ptr = ptr;
    next_run = run;
    next_rdata = 8'h00;
    host_ram_we = 1'b0;
    // Engine consumption leaves the byte itself untouched
    if (eng_take_i)
      next_host_new = 1'b0;
    // Posted byte is held until the host acks
    if (eng_post_i && post_ready)
      next_dev_cmd = eng_post_byte_i;
    if (bus.wr)
    begin
      if (bus.addr == `HCM_OFS_MASK)
      begin
        next_mask = bus.wdata & `HCM_FLAG_MASK;
      end
      else if (bus.addr == `HCM_OFS_HOST_CMD)
      begin
        next_host_cmd = bus.wdata;
        next_host_new = 1'b1;
      end
      else if (bus.addr == `HCM_OFS_INIT)
      begin
        next_run = 1'b1;
      end
      else if (bus.addr == `HCM_OFS_PTR_HI)
      begin
        next_ptr = RAM_AW'({bus.wdata, ptr[7:0]});
      end
      else if (bus.addr == `HCM_OFS_PTR_LO)
      begin
        next_ptr = RAM_AW'({ptr >> 8, bus.wdata});
      end
      else if (bus.addr == `HCM_OFS_RAM_NEXT)
      begin
        host_ram_we = 1'b1;
        next_ptr = ptr + RAM_AW'(1);
      end
      else if (bus.addr == `HCM_OFS_RAM_CUR)
      begin
        host_ram_we = 1'b1;
      end
    end
    if (bus.rd)
    begin
      if (bus.addr == `HCM_OFS_MASK)
        next_rdata = mask;
      else if (bus.addr == `HCM_OFS_CAUSE)
        next_rdata = flags;
      else if (bus.addr == `HCM_OFS_HOST_CMD)
        next_rdata = host_cmd;
      else if (bus.addr == `HCM_OFS_DEV_CMD)
        next_rdata = dev_cmd;
      else if (bus.addr == `HCM_OFS_PTR_HI)
      begin
        next_rdata = 8'(ptr >> 8);
      end
      else if (bus.addr == `HCM_OFS_PTR_LO)
      begin
        next_rdata = ptr[7:0];
      end
      else if (bus.addr == `HCM_OFS_RAM_NEXT)
      begin
        next_rdata = ram[ptr];
        next_ptr = ptr + RAM_AW'(1);
      end
      else if (bus.addr == `HCM_OFS_RAM_CUR)
      begin
        next_rdata = ram[ptr];
      end
      else
      begin
        next_rdata = 8'h00;
      end
    end
    // Engine may post again only once bit 2 is clear
    next_post_ready = ~next_flags[`HCM_BIT_DEV_POSTED];
    next_irq = |(next_flags & next_mask);
  end

  // ****************************************************
  // Register file flops
  // ****************************************************
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      flags <= `HCM_RST_BYTE;
      mask <= `HCM_RST_BYTE;
      host_cmd <= `HCM_RST_BYTE;
      dev_cmd <= `HCM_RST_BYTE;
      rdata <= `HCM_RST_BYTE;
      ptr <= '0;
      host_new <= 1'b0;
      run <= 1'b0;
      post_ready <= 1'b1;
      irq <= 1'b0;
    end
    else
    begin
      flags <= next_flags;
      mask <= next_mask;
      host_cmd <= next_host_cmd;
      dev_cmd <= next_dev_cmd;
      rdata <= next_rdata;
      ptr <= next_ptr;
      host_new <= next_host_new;
      run <= next_run;
      post_ready <= next_post_ready;
      irq <= next_irq;
    end
  end

  // ****************************************************
  // Shared RAM, host port has priority on a collision
  // ****************************************************
  always_ff @(posedge core_clk_i)
  begin
    if (host_ram_we)
    begin
      ram[ptr] <= bus.wdata;
    end
    else if (eng_ram_we_i)
    begin
      ram[eng_ram_addr_i] <= eng_ram_wdata_i;
    end
    eng_ram_rdata_o <= ram[eng_ram_addr_i];
  end

  // ****************************************************
  // Outputs, all straight from flops
  // ****************************************************
  assign bus.rdata = rdata;
  assign bus.irq = irq;
  assign host_cmd_o = host_cmd;
  assign host_cmd_new_o = host_new;
  assign eng_post_ready_o = post_ready;
  assign engine_run_o = run;

endmodule : hcm_dev_end

`default_nettype wire

// ---- hw/hcm_host_end.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hcm_defs.svh"

module hcm_host_end (
  input wire logic core_clk_i, // System clock, 40 MHz
  input wire logic rstn_i, // Async reset, active low
  hcm_bus_if.host bus, // Micro bus toward the device
  input wire logic [3:0] cmd_addr_i, // Register address
  input wire logic [7:0] cmd_wdata_i, // Write data
  input wire logic cmd_wr_i, // Write strobe, one cycle
  input wire logic cmd_rd_i, // Read strobe, one cycle
  output logic [7:0] cmd_rdata_o, // Read data
  output logic cmd_rvalid_o, // Read data valid, one cycle
  output logic irq_o // Device interrupt, registered
);

  // ****************************************************
  // State
  // ****************************************************
  hcm_pkg::hcm_acc_e acc, next_acc;
  hcm_pkg::hcm_addr_t addr, next_addr;
  hcm_pkg::hcm_byte_t wdata, next_wdata;
  hcm_pkg::hcm_byte_t rdata, next_rdata;
  logic rd_wait, next_rd_wait;
  logic rvalid, next_rvalid;
  logic irq, next_irq;

  // ****************************************************
  // Request staging and answer capture
  // ****************************************************
  always_comb
  begin
    next_acc = hcm_pkg::HCM_ACC_IDLE;
    next_addr = addr;
    next_wdata = wdata;
    // Image load and commands are plain single-byte writes
    if (cmd_wr_i)
    begin
      next_acc = hcm_pkg::HCM_ACC_WRITE;
      next_addr = cmd_addr_i;
      next_wdata = cmd_wdata_i;
      // Forcing bit 2 would interrupt the host itself
      if (cmd_addr_i == `HCM_OFS_FORCE)
      begin
        next_wdata[`HCM_BIT_DEV_POSTED] = 1'b0;
      end
    end
    else if (cmd_rd_i)
    begin
      next_acc = hcm_pkg::HCM_ACC_READ;
      next_addr = cmd_addr_i;
    end
    // Device answers one cycle after its read strobe
    next_rd_wait = (acc == hcm_pkg::HCM_ACC_READ);
    next_rvalid = rd_wait;
    next_rdata = rd_wait ? bus.rdata : rdata;
    next_irq = bus.irq;
  end

  // ****************************************************
  // Flops
  // ****************************************************
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      acc <= hcm_pkg::HCM_ACC_IDLE;
      addr <= 4'h0;
      wdata <= `HCM_RST_BYTE;
      rdata <= `HCM_RST_BYTE;
      rd_wait <= 1'b0;
      rvalid <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      acc <= next_acc;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      rd_wait <= next_rd_wait;
      rvalid <= next_rvalid;
      irq <= next_irq;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign bus.addr = addr;
  assign bus.wdata = wdata;
  assign bus.wr = (acc == hcm_pkg::HCM_ACC_WRITE);
  assign bus.rd = (acc == hcm_pkg::HCM_ACC_READ);
  assign cmd_rdata_o = rdata;
  assign cmd_rvalid_o = rvalid;
  assign irq_o = irq;

endmodule : hcm_host_end

`default_nettype wire

// ---- hw/hcm_pkg.sv ----
`default_nettype none
package hcm_pkg;

  // One byte on the micro bus
  typedef logic [7:0] hcm_byte_t;

  // Micro bus address
  typedef logic [3:0] hcm_addr_t;

  // Kind of access the host end puts on the bus
  typedef enum logic [1:0] {
    HCM_ACC_IDLE,
    HCM_ACC_WRITE,
    HCM_ACC_READ
  } hcm_acc_e;

endpackage : hcm_pkg

`default_nettype wire

// ---- tb/hcm_bus_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************
// Micro bus checker
// ****************************************************
module hcm_bus_assertions (
  input wire logic core_clk_i, // Clock
  input wire logic rstn_i, // Reset, active low
  input wire hcm_pkg::hcm_addr_t addr, // Address
  input wire hcm_pkg::hcm_byte_t wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire hcm_pkg::hcm_byte_t rdata, // Read data
  input wire logic irq // Interrupt line
);
  logic [7:0] msk;
  logic [7:0] next_msk;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  // Shadow of the enable mask, next value
  always_comb
  begin
    next_msk = msk;
    if (wr && addr == 4'h1)
      next_msk = wdata & 8'h07;
  end

  // Shadow of the enable mask, register
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      msk <= 8'h00;
    else
      msk <= next_msk;
  end

  a_init_reads_zero: assert property (
    rd && addr == 4'h5 |=> rdata == 8'h00) else $error("init trigger read not zero");
  a_force_reads_zero: assert property (
    rd && addr == 4'h6 |=> rdata == 8'h00) else $error("force read not zero");
  a_cause_reserved_zero: assert property (
    rd && addr == 4'h2 |=> rdata[7:3] == 5'h00) else $error("cause upper bits set");
  a_mask_reserved_zero: assert property (
    rd && addr == 4'h1 |=> rdata[7:3] == 5'h00) else $error("mask upper bits set");
  a_cmd_byte_kept: assert property (
    wr && addr == 4'h3 ##1 rd && addr == 4'h3 |=> rdata == $past(wdata, 2))
    else $error("host command readback wrong");
  a_taken_clear_one: assert property (
    wr && addr == 4'h2 && wdata[0] ##1 rd && addr == 4'h2 |=> !rdata[0])
    else $error("host taken not cleared");
  a_new_cmd_clears: assert property (
    wr && addr == 4'h3 ##1 rd && addr == 4'h2 |=> !rdata[0])
    else $error("new command left flag set");
  a_irq_and_or: assert property (
    rd && addr == 4'h2 |=> $past(irq) == |(rdata & $past(msk))) else $error("irq not flags and mask");

  // Main scenarios seen
  c_cause_read: cover property (rd && addr == 4'h2);
  c_force_write: cover property (wr && addr == 4'h6);
  c_irq_rise: cover property ($rose(irq));
endmodule : hcm_bus_assertions

`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] cmd_addr_i = 4'h0;
  logic [7:0] cmd_wdata_i = 8'h00;
  logic cmd_wr_i = 1'b0, cmd_rd_i = 1'b0;
  logic eng_take_i = 1'b0, eng_post_i = 1'b0, eng_ram_we_i = 1'b0;
  logic serial_bus_reset_i = 1'b0;
  logic [7:0] eng_post_byte_i = 8'h00, eng_ram_addr_i = 8'h00, eng_ram_wdata_i = 8'h00;
  logic [7:0] cmd_rdata_o, host_cmd_o, eng_ram_rdata_o;
  logic cmd_rvalid_o, irq_o, host_cmd_new_o, eng_post_ready_o, engine_run_o;
  logic [31:0] seed = 32'h0000_002a;
  logic [7:0] exp_q[$];
  logic [7:0] v, p;
  int error_cnt = 0, comparisons = 0;

  // ****************************************************
  // Clock, design and checker
  // ****************************************************
  always #12.5 core_clk_i = ~core_clk_i;

  hcm_bus_if bus_if ();
  hcm_dev_end #(.RAM_AW(8)) hcm_dev_end_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .bus(bus_if),
    .eng_take_i(eng_take_i), .host_cmd_o(host_cmd_o), .host_cmd_new_o(host_cmd_new_o),
    .eng_post_i(eng_post_i), .eng_post_byte_i(eng_post_byte_i), .eng_post_ready_o(eng_post_ready_o),
    .eng_ram_we_i(eng_ram_we_i), .eng_ram_addr_i(eng_ram_addr_i), .eng_ram_wdata_i(eng_ram_wdata_i),
    .eng_ram_rdata_o(eng_ram_rdata_o), .serial_bus_reset_i(serial_bus_reset_i), .engine_run_o(engine_run_o));
  hcm_host_end hcm_host_end_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .bus(bus_if),
    .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i),
    .cmd_rdata_o(cmd_rdata_o), .cmd_rvalid_o(cmd_rvalid_o), .irq_o(irq_o));
  hcm_bus_assertions hcm_bus_assertions_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd),
    .rdata(bus_if.rdata), .irq(bus_if.irq));

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk

  // One host access per cycle, reads note their expectation
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    cmd_wr_i <= w;
    cmd_rd_i <= !w;
    cmd_addr_i <= a;
    cmd_wdata_i <= d;
    if (!w)
      exp_q.push_back(d);
    @(posedge core_clk_i);
  endtask : acc

  // Bus idle for n cycles, ends mid-cycle so outputs are settled
  task automatic idle(input int n);
    cmd_wr_i <= 1'b0;
    cmd_rd_i <= 1'b0;
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : idle

  task automatic eng(input logic t, input logic ps, input logic [7:0] b);
    @(posedge core_clk_i);
    eng_take_i <= t;
    eng_post_i <= ps;
    eng_post_byte_i <= b;
    @(posedge core_clk_i);
    eng_take_i <= 1'b0;
    eng_post_i <= 1'b0;
  endtask : eng

  task automatic summarize();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  // Read answers are matched in order against the noted values
  always @(posedge core_clk_i)
  begin
    if (cmd_rvalid_o === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("rvalid", 8'h01, 8'h00);
      else
        chk("rdata", cmd_rdata_o, exp_q.pop_front());
    end
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial
  begin
    repeat (8) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    for (int a = 1; a < 8; a++) acc(1'b0, a[3:0], 8'h00);
    idle(2);
    chk("irq", {7'h00, irq_o}, 8'h00);
    v = rnd();
    @(posedge core_clk_i);
    acc(1'b1, 4'h3, v);
    acc(1'b0, 4'h3, v);
    idle(1);
    chk("newcmd", {7'h00, host_cmd_new_o}, 8'h01);
    chk("hostcmd", host_cmd_o, v);
    eng(1'b1, 1'b0, 8'h00);
    acc(1'b0, 4'h2, 8'h01);
    acc(1'b0, 4'h3, v);
    acc(1'b1, 4'h2, 8'h00);
    acc(1'b0, 4'h2, 8'h01);
    acc(1'b1, 4'h2, 8'h01);
    acc(1'b0, 4'h2, 8'h00);
    idle(1);
    eng(1'b1, 1'b0, 8'h00);
    acc(1'b1, 4'h3, rnd());
    acc(1'b0, 4'h2, 8'h00);
    acc(1'b1, 4'h1, 8'hff);
    acc(1'b0, 4'h1, 8'h07);
    idle(1);
    p = rnd();
    @(posedge core_clk_i);
    eng_ram_addr_i <= 8'h20;
    eng_ram_wdata_i <= ~p;
    eng_ram_we_i <= 1'b1;
    eng(1'b0, 1'b1, p);
    eng_ram_we_i <= 1'b0;
    eng(1'b0, 1'b1, ~p);
    idle(3);
    chk("irq", {7'h00, irq_o}, 8'h01);
    chk("ready", {7'h00, eng_post_ready_o}, 8'h00);
    @(posedge core_clk_i);
    acc(1'b0, 4'h2, 8'h04);
    acc(1'b0, 4'h4, p);
    acc(1'b1, 4'hd, 8'h20);
    acc(1'b0, 4'hf, ~p);
    acc(1'b1, 4'h2, 8'h04);
    acc(1'b0, 4'h4, p);
    idle(3);
    chk("irq", {7'h00, irq_o}, 8'h00);
    chk("ready", {7'h00, eng_post_ready_o}, 8'h01);
    chk("engram", eng_ram_rdata_o, ~p);
    @(posedge core_clk_i);
    acc(1'b1, 4'h6, 8'h00);
    acc(1'b0, 4'h2, 8'h00);
    acc(1'b1, 4'h6, 8'hff);
    acc(1'b0, 4'h2, 8'h01);
    acc(1'b0, 4'h6, 8'h00);
    acc(1'b1, 4'h1, 8'h06);
    idle(3);
    chk("irq", {7'h00, irq_o}, 8'h00);
    @(posedge core_clk_i);
    acc(1'b1, 4'h2, 8'h01);
    acc(1'b1, 4'h5, rnd());
    acc(1'b0, 4'h5, 8'h00);
    serial_bus_reset_i <= 1'b1;
    idle(6);
    chk("run", {7'h00, engine_run_o}, 8'h01);
    chk("irq", {7'h00, irq_o}, 8'h01);
    @(posedge core_clk_i);
    acc(1'b0, 4'h2, 8'h02);
    acc(1'b1, 4'hc, 8'h00);
    acc(1'b1, 4'hd, 8'h10);
    acc(1'b1, 4'he, v);
    acc(1'b1, 4'he, ~v);
    acc(1'b1, 4'hd, 8'h10);
    acc(1'b0, 4'he, v);
    acc(1'b0, 4'hf, ~v);
    idle(1);
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge core_clk_i);
    // Second reset mid-run must clear mask, cause, command bytes and run; RAM is not cleared
    serial_bus_reset_i <= 1'b0;
    rstn_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    for (int a = 1; a < 5; a++) acc(1'b0, a[3:0], 8'h00);
    idle(1);
    chk("irq", {7'h00, irq_o}, 8'h00);
    chk("run", {7'h00, engine_run_o}, 8'h00);
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge core_clk_i);
    if (exp_q.size() != 0)
      chk("drain", 8'h01, 8'h00);
    summarize();
  end
endmodule : tb

`default_nettype wire
